// ==== include/stcir_pkg.sv ====
/*
 * stcir_pkg: constants and carrier types for the indirect statistics counter
 * read path. Assumes one 20 MHz core clock and 8-bit management registers.
 */
package stcir_pkg;
    // management register offsets
    localparam logic [7:0] OFS_SELECT = 8'h79;
    localparam logic [7:0] OFS_TRIGGER = 8'h7A;
    localparam logic [7:0] OFS_DATA_TOP = 8'h80;
    localparam logic [7:0] OFS_DATA_UPPER = 8'h81;
    localparam logic [7:0] OFS_DATA_MIDDLE = 8'h82;
    localparam logic [7:0] OFS_DATA_LOW = 8'h83;
    // reset values
    localparam logic [7:0] RST_SELECT = 8'h00;
    localparam logic [7:0] RST_TRIGGER = 8'h00;
    localparam logic [31:0] RST_DATA = 32'h00000000;
    // select codes written by software
    localparam logic [7:0] SEL_PORT_BANK = 8'h1C;
    localparam logic [7:0] SEL_DROP_BANK = 8'h1D;
    // returned word fields
    localparam int OVF_BIT = 31;
    localparam int VALID_BIT = 30;
    localparam int CNT_W = 30;
    localparam int DROP_W = 16;
    // counter slot layout
    localparam int N_PORT_CNT = 96;
    localparam int N_DROP_CNT = 6;
    localparam int N_SLOT = 102;
    localparam logic [9:0] DROP_BASE = 10'h100;
    localparam logic [9:0] PORT_LIMIT = 10'h060;
    // software polling interval and worst overflow time, in seconds
    localparam int POLL_SEC = 30;
    localparam int OVERFLOW_SEC = 120;

    // fetch sequencer, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FETCH = 3'b010,
        ST_LATCH = 3'b100
    } stcir_state_t;

    // one management register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } stcir_req_t;

    // decoded counter index
    typedef struct packed {
        logic hit;
        logic drop;
        logic [6:0] slot;
    } stcir_map_t;
endpackage

// ==== design/stcir_cnt_mem.sv ====
/*
 * stcir_cnt_mem: storage for all statistics counters with one registered
 * read port and an optional clear of the entry being read.
 * Assumes increments are one-cycle pulses synchronous to clk_sys_i.
 */
`timescale 1ns/1ns
module stcir_cnt_mem
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // count events, one bit per slot
    input wire logic [101:0] inc_i,
    // read port
    input wire logic rd_en_i,
    input wire logic [6:0] rd_slot_i,
    input wire logic clr_i,
    output logic [30:0] rd_data_o
);
    logic [30:0] cnt_ff [0:101];
    logic [30:0] nxt_cnt [0:101];
    logic [30:0] rd_data_ff;
    logic [30:0] nxt_rd_data;

    // next counter values; an event in the clearing cycle still counts
    always_comb
    begin
        logic [30:0] base;
        base = '0;
        for (int i = 0; i < stcir_pkg::N_SLOT; i++)
        begin
            base = (rd_en_i && clr_i && rd_slot_i == 7'(i)) ? 31'h00000000 : cnt_ff[i];
            nxt_cnt[i] = base;
            if (inc_i[i])
            begin
                if (i < stcir_pkg::N_PORT_CNT)
                begin
                    // sticky wrap flag above a 30-bit count
                    nxt_cnt[i] = {base[30] | (&base[29:0]), base[29:0] + 30'h00000001};
                end
                else
                begin
                    // drop counters just wrap, no flag kept
                    nxt_cnt[i] = {15'h0000, base[15:0] + 16'h0001};
                end
            end
        end
        nxt_rd_data = rd_en_i ? cnt_ff[rd_slot_i] : rd_data_ff;
    end

    // register stage
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < stcir_pkg::N_SLOT; i++)
            begin
                cnt_ff[i] <= 31'h00000000;
            end
            rd_data_ff <= 31'h00000000;
        end
        else
        begin
            for (int i = 0; i < stcir_pkg::N_SLOT; i++)
            begin
                cnt_ff[i] <= nxt_cnt[i];
            end
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data_o = rd_data_ff;

    a_clear_on_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_en_i && clr_i && !inc_i[rd_slot_i] |=> cnt_ff[$past(rd_slot_i)] == 31'h00000000)
        else $error("read-clear counter not zero after read");
    a_drop_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_en_i && !clr_i && !inc_i[rd_slot_i] |=> cnt_ff[$past(rd_slot_i)] == $past(cnt_ff[rd_slot_i]))
        else $error("counter changed by a non-clearing read");
endmodule

// ==== design/stcir_top.sv ====
/*
 * stcir_top: indirect read path of the switch statistics counters.
 * Software writes a select byte and a trigger byte, then reads four data
 * bytes. Assumes the management serial bus front end presents each 8-bit
 * register access as a one-cycle request synchronous to clk_sys_i.
 */
`timescale 1ns/1ns
// How it works
// - select value 0x1D points reads at the all-port dropped-packet bank
// - trigger write 0x00 after that selection starts the port one transmit drop read
// - drop counter bits 15..8 appear at 0x82, bits 7..0 at 0x83
// - per-port counters clear themselves when read
// - drop counters keep value when read and carry no overflow or valid flags
// - per-port read word carries overflow in bit 31
// - bit 30 shows valid; when zero software rereads from the first data byte
module stcir_top
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // management register access
    input wire stcir_pkg::stcir_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    // counter events: three ports of 32 counters, then six drop counters
    input wire logic [95:0] port_inc_i,
    input wire logic [5:0] drop_inc_i,
    // fetch status
    output logic fetch_busy_o
);
    logic rst_meta_ff;
    logic rst_n_ff;
    logic [7:0] select_ff;
    logic [7:0] nxt_select;
    logic [7:0] trigger_ff;
    logic [7:0] nxt_trigger;
    logic [9:0] index_ff;
    logic [9:0] nxt_index;
    logic [31:0] data_ff;
    logic [31:0] nxt_data;
    logic valid_ff;
    logic nxt_valid;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    stcir_pkg::stcir_state_t state_ff;
    stcir_pkg::stcir_state_t nxt_state;
    stcir_pkg::stcir_map_t map;
    logic trig_wr;
    logic mem_rd_en;
    logic mem_clr;
    logic [30:0] mem_rdata;

    // index to counter slot; anything outside both banks is a miss
    function automatic stcir_pkg::stcir_map_t map_index(input logic [9:0] idx);
        stcir_pkg::stcir_map_t m;
        m.hit = 1'b0;
        m.drop = 1'b0;
        m.slot = 7'h00;
        if (idx < stcir_pkg::PORT_LIMIT)
        begin
            m.hit = 1'b1;
            m.slot = idx[6:0];
        end
        else if (idx >= stcir_pkg::DROP_BASE && idx < stcir_pkg::DROP_BASE + 10'(stcir_pkg::N_DROP_CNT))
        begin
            m.hit = 1'b1;
            m.drop = 1'b1;
            m.slot = 7'(stcir_pkg::N_PORT_CNT) + {4'h0, idx[2:0]};
        end
        return m;
    endfunction

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    assign trig_wr = reg_req_i.wr && reg_req_i.addr == stcir_pkg::OFS_TRIGGER;
    assign map = map_index(index_ff);

    // select and trigger registers, index formed when the trigger is written
    always_comb
    begin
        nxt_select = select_ff;
        nxt_trigger = trigger_ff;
        nxt_index = index_ff;
        if (reg_req_i.wr && reg_req_i.addr == stcir_pkg::OFS_SELECT)
        begin
            nxt_select = reg_req_i.wdata;
        end
        if (trig_wr)
        begin
            nxt_trigger = reg_req_i.wdata;
            nxt_index = {select_ff[1:0], reg_req_i.wdata};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            select_ff <= stcir_pkg::RST_SELECT;
            trigger_ff <= stcir_pkg::RST_TRIGGER;
            index_ff <= 10'h000;
        end
        else
        begin
            select_ff <= nxt_select;
            trigger_ff <= nxt_trigger;
            index_ff <= nxt_index;
        end
    end

    // fetch sequencer; a new trigger restarts a fetch in flight
    always_comb
    begin
        nxt_state = state_ff;
        nxt_data = data_ff;
        nxt_valid = valid_ff;
        mem_rd_en = 1'b0;
        mem_clr = 1'b0;
        case (state_ff)
            stcir_pkg::ST_IDLE:
            begin
                nxt_state = stcir_pkg::ST_IDLE;
            end
            stcir_pkg::ST_FETCH:
            begin
                mem_rd_en = map.hit;
                mem_clr = map.hit && !map.drop;
                nxt_state = stcir_pkg::ST_LATCH;
            end
            stcir_pkg::ST_LATCH:
            begin
                nxt_valid = 1'b1;
                if (!map.hit)
                begin
                    nxt_data = stcir_pkg::RST_DATA;
                end
                else if (map.drop)
                begin
                    // reserved upper bits read zero, no flags for this bank
                    nxt_data = {16'h0000, mem_rdata[15:0]};
                end
                else
                begin
                    nxt_data = {mem_rdata[30], 1'b1, mem_rdata[29:0]};
                end
                nxt_state = stcir_pkg::ST_IDLE;
            end
            default:
            begin
                nxt_state = stcir_pkg::ST_IDLE;
            end
        endcase
        if (trig_wr)
        begin
            nxt_valid = 1'b0;
            nxt_state = stcir_pkg::ST_FETCH;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            state_ff <= stcir_pkg::ST_IDLE;
            data_ff <= stcir_pkg::RST_DATA;
            valid_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            data_ff <= nxt_data;
            valid_ff <= nxt_valid;
        end
    end

    // register read; valid bit tracks the fetch so polling software can retry
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (reg_req_i.rd)
        begin
            case (reg_req_i.addr)
                stcir_pkg::OFS_SELECT: nxt_rdata = select_ff;
                stcir_pkg::OFS_TRIGGER: nxt_rdata = trigger_ff;
                stcir_pkg::OFS_DATA_TOP:
                begin
                    if (map.drop)
                    begin
                        nxt_rdata = data_ff[31:24];
                    end
                    else
                    begin
                        nxt_rdata = {data_ff[31], valid_ff, data_ff[29:24]};
                    end
                end
                stcir_pkg::OFS_DATA_UPPER: nxt_rdata = data_ff[23:16];
                stcir_pkg::OFS_DATA_MIDDLE: nxt_rdata = data_ff[15:8];
                stcir_pkg::OFS_DATA_LOW: nxt_rdata = data_ff[7:0];
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            rdata_ff <= 8'h00;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // counter storage; a whole array of flops is traded for single-cycle updates
    stcir_cnt_mem u_mem
    (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_ff),
        .inc_i({drop_inc_i, port_inc_i}),
        .rd_en_i(mem_rd_en),
        .rd_slot_i(map.slot),
        .clr_i(mem_clr),
        .rd_data_o(mem_rdata)
    );

    assign reg_rdata_o = rdata_ff;
    assign fetch_busy_o = state_ff != stcir_pkg::ST_IDLE; // software still sees valid low

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_ff);

    // a trigger followed by two quiet cycles, so no restart can hide the result
    sequence s_trig_quiet;
        trig_wr ##1 !trig_wr [*2];
    endsequence

    a_index_form: assert property (
        trig_wr |=> index_ff == {$past(select_ff[1:0]), $past(reg_req_i.wdata)})
        else $error("index not formed from select and trigger");
    a_sel_drop_bank: assert property (
        trig_wr && select_ff == stcir_pkg::SEL_DROP_BANK && reg_req_i.wdata < 8'h06 |=> map.hit && map.drop)
        else $error("drop select did not reach the drop bank");
    a_sel_port_bank: assert property (
        trig_wr && select_ff == stcir_pkg::SEL_PORT_BANK && reg_req_i.wdata < 8'h60 |=> map.hit && !map.drop)
        else $error("port select did not reach the port bank");
    a_trig_starts: assert property (
        trig_wr |=> state_ff == stcir_pkg::ST_FETCH && mem_rd_en == map.hit)
        else $error("trigger did not start a fetch");
    a_valid_flow: assert property (
        s_trig_quiet |-> !$past(valid_ff) && !valid_ff ##1 valid_ff)
        else $error("valid did not rise two cycles after trigger");
    a_byte_place: assert property (
        state_ff == stcir_pkg::ST_LATCH && map.drop && !trig_wr
        |=> data_ff[15:0] == $past(mem_rdata[15:0]) && data_ff[31:16] == 16'h0000)
        else $error("drop counter bytes misplaced or flags present");
    a_byte_read: assert property (
        reg_req_i.rd && reg_req_i.addr == stcir_pkg::OFS_DATA_MIDDLE |=> reg_rdata_o == $past(data_ff[15:8]))
        else $error("middle data byte wrong");
    a_ovf_report: assert property (
        state_ff == stcir_pkg::ST_LATCH && map.hit && !map.drop && !trig_wr
        |=> data_ff[31] == $past(mem_rdata[30]) && data_ff[30])
        else $error("overflow bit not reported");
    a_port_clear: assert property (
        state_ff == stcir_pkg::ST_FETCH && map.hit |-> mem_clr == !map.drop)
        else $error("clear-on-read applied to wrong bank");
endmodule

// ==== verif/tb_stats_counter_indirect_read.sv ====
/*
 * tb_stats_counter_indirect_read: self-checking bench for stcir_top.
 * Drives the management request struct and the counter event pulses directly.
 * Assumes one 20 MHz clock and the fixed fetch timing of the design.
 */
`timescale 1ns/1ns
module tb_stats_counter_indirect_read;
    // design connections
    logic clk_sys_i;
    logic nrst_i;
    stcir_pkg::stcir_req_t reg_req_i;
    logic [7:0] reg_rdata_o;
    logic [95:0] port_inc_i;
    logic [5:0] drop_inc_i;
    logic fetch_busy_o;
    // bookkeeping
    int failures;
    int check_count;
    logic [31:0] word;
    logic [7:0] rb;

    stcir_top dut
    (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .reg_req_i(reg_req_i),
        .reg_rdata_o(reg_rdata_o),
        .port_inc_i(port_inc_i),
        .drop_inc_i(drop_inc_i),
        .fetch_busy_o(fetch_busy_o)
    );

    // 50 ns core clock
    initial
    begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    // compare tasks, one per result width
    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask

    // verdict and end of run, shared by the main sequence and the watchdog
    task automatic wrap_up();
        if (failures == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one write request, taken at exactly one edge
    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_sys_i);
        reg_req_i <= {1'b1, 1'b0, addr, data};
        @(posedge clk_sys_i);
        reg_req_i <= '0;
    endtask

    // one read request; data is registered at the taken edge and sampled one edge later
    task automatic reg_rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_sys_i);
        reg_req_i <= {1'b0, 1'b1, addr, 8'h00};
        @(posedge clk_sys_i);
        reg_req_i <= '0;
        @(posedge clk_sys_i);
        #1;
        data = reg_rdata_o;
    endtask

    // select, trigger, wait out the fixed two-edge fetch, then read 0x80..0x83
    task automatic fetch(input logic [7:0] sel, input logic [7:0] trig, output logic [31:0] w);
        logic [7:0] b;
        reg_wr(stcir_pkg::OFS_SELECT, sel);
        reg_wr(stcir_pkg::OFS_TRIGGER, trig);
        #1;
        check_bit("busy during fetch", 1'b1, fetch_busy_o);
        repeat (2) @(posedge clk_sys_i);
        #1;
        check_bit("busy after fetch", 1'b0, fetch_busy_o);
        for (int k = 0; k < 4; k++)
        begin
            reg_rd(stcir_pkg::OFS_DATA_TOP + 8'(k), b);
            w[31 - 8 * k -: 8] = b;
        end
    endtask

    // count events as one-cycle pulses with an idle cycle between them
    task automatic bump(input bit drop, input int idx, input int n);
        repeat (n)
        begin
            @(posedge clk_sys_i);
            if (drop)
                drop_inc_i[idx] <= 1'b1;
            else
                port_inc_i[idx] <= 1'b1;
            @(posedge clk_sys_i);
            drop_inc_i <= '0;
            port_inc_i <= '0;
        end
    endtask

    // watchdog: the whole sequence needs well under 3000 cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        wrap_up();
    end

    // main sequence
    initial
    begin
        failures = 0;
        check_count = 0;
        nrst_i = 1'b0;
        reg_req_i = '0;
        port_inc_i = '0;
        drop_inc_i = '0;
        repeat (20) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        // the release passes two flops, so the first request waits three edges
        repeat (3) @(posedge clk_sys_i);

        // reset values of all mapped registers and of the unmapped holes around them
        for (int a = 8'h79; a <= 8'h84; a++)
        begin
            reg_rd(8'(a), rb);
            check_byte("reset readback", 8'h00, rb);
        end
        reg_wr(stcir_pkg::OFS_SELECT, stcir_pkg::SEL_PORT_BANK);
        reg_rd(stcir_pkg::OFS_SELECT, rb);
        check_byte("select readback", 8'h1C, rb);
        // data bytes are read-only, a write must leave them untouched
        reg_wr(stcir_pkg::OFS_DATA_LOW, 8'hA5);
        reg_rd(stcir_pkg::OFS_DATA_LOW, rb);
        check_byte("data byte write ignored", 8'h00, rb);

        // drop bank: first counter goes past 255 so both bytes carry bits
        for (int i = 0; i < 6; i++)
            bump(1'b1, i, (i == 0) ? 300 : i + 1);
        for (int i = 0; i < 6; i++)
        begin
            fetch(stcir_pkg::SEL_DROP_BANK, 8'(i), word);
            check_word("drop counter", {16'h0000, 16'((i == 0) ? 300 : i + 1)}, word);
        end
        // a second read finds the drop value still there
        fetch(stcir_pkg::SEL_DROP_BANK, 8'h00, word);
        check_word("drop counter kept", 32'h0000012C, word);

        // per-port counters: second port offset 0x0E and the last slot 0x5F
        bump(1'b0, 46, 5);
        bump(1'b0, 95, 2);
        fetch(stcir_pkg::SEL_PORT_BANK, 8'h2E, word);
        check_word("port counter", 32'h40000005, word);
        fetch(stcir_pkg::SEL_PORT_BANK, 8'h2E, word);
        check_word("port counter cleared", 32'h40000000, word);
        fetch(stcir_pkg::SEL_PORT_BANK, 8'h5F, word);
        check_word("last port counter", 32'h40000002, word);
        fetch(stcir_pkg::SEL_PORT_BANK, 8'h5F, word);
        check_word("last port counter cleared", 32'h40000000, word);
        // a top-byte read while the fetch runs sees valid low; a reread afterwards sees the word
        bump(1'b0, 3, 1);
        reg_wr(stcir_pkg::OFS_TRIGGER, 8'h03);
        reg_rd(stcir_pkg::OFS_DATA_TOP, rb);
        check_byte("top byte during fetch", 8'h00, rb);
        reg_rd(stcir_pkg::OFS_DATA_TOP, rb);
        check_byte("top byte reread", 8'h40, rb);
        reg_rd(stcir_pkg::OFS_DATA_LOW, rb);
        check_byte("low byte reread", 8'h01, rb);
        reg_rd(stcir_pkg::OFS_TRIGGER, rb);
        check_byte("trigger readback", 8'h03, rb);
        // an index past the last port counter maps to nothing and reads as an empty valid word
        fetch(stcir_pkg::SEL_PORT_BANK, 8'h60, word);
        check_word("unmapped index", 32'h40000000, word);
        // port reads must not disturb the drop bank
        fetch(stcir_pkg::SEL_DROP_BANK, 8'h05, word);
        check_word("drop counter after port reads", 32'h00000006, word);
        wrap_up();
    end
endmodule
